// ===== gpm_pkg.sv
// Constants, register map and carrier types of the GPIO pin function multiplexer.
// Assumes a 32-bit Avalon-MM slave port with byte addresses; register index = byte address / 4.
package gpm_pkg;
    localparam int NPORT = 6;
    localparam int PIN_MAX = 8;
    // Two-bit pin select codes
    localparam logic [1:0] SEL_GPI = 2'h0;
    localparam logic [1:0] SEL_FN1 = 2'h1;
    localparam logic [1:0] SEL_GPO = 2'h2;
    localparam logic [1:0] SEL_FN2 = 2'h3;
    // Register indices (byte address is four times the index)
    localparam logic [13:0] IDX_SEL_A = 14'h0C02;
    localparam logic [13:0] IDX_SEL_B = 14'h0C06;
    localparam logic [13:0] IDX_SEL_C = 14'h0C0A;
    localparam logic [13:0] IDX_SEL_D = 14'h0C0E;
    localparam logic [13:0] IDX_SEL_G = 14'h0C1A;
    localparam logic [13:0] IDX_SEL_H = 14'h0C1E;
    localparam logic [13:0] IDX_OUT_BASE = 14'h0C40;
    localparam logic [13:0] IDX_IN_BASE = 14'h0C48;
    localparam logic [13:0] IDX_MODE = 14'h0C50;
    localparam logic [13:0] SEL_IDX [NPORT] = '{IDX_SEL_A, IDX_SEL_B, IDX_SEL_C, IDX_SEL_D, IDX_SEL_G, IDX_SEL_H};
    // Implemented select bits per port; the rest read as zero
    localparam logic [15:0] WMASK_A = 16'hFFFF;
    localparam logic [15:0] WMASK_D = 16'h00FF;
    localparam logic [15:0] WMASK_G = 16'h03FF;
    localparam logic [15:0] WMASK_H = 16'h0C00;
    localparam logic [15:0] SEL_WMASK [NPORT] = '{WMASK_A, WMASK_A, WMASK_A, WMASK_D, WMASK_G, WMASK_H};
    localparam int H_SEL_LSB = 10;
    localparam int MODE_CAM16_BIT = 0;
    // Reset values
    localparam logic [15:0] SEL_RST = 16'h0000;
    localparam logic [7:0] GPO_RST = 8'h00;
    // Pins whose second-function code is reserved: port B, port H, none
    localparam logic [7:0] RSVD2_B = 8'h70;
    localparam logic [7:0] RSVD2_H = 8'hFF;
    localparam logic [7:0] RSVD2_NONE = 8'h00;
    // Drive from an internal function toward a port: value and active-low enable per pin
    typedef struct packed {
        logic [7:0] o;
        logic [7:0] oe_n;
    } gpm_drv_s;
endpackage

// ===== gpm_port_mux.sv
// One port's pin multiplexer: per-pin two-bit select, pin drive and input routing.
// Assumes pin inputs are asynchronous; select and drive inputs are on clk.
`timescale 1ns/1ps
module gpm_port_mux #(
    parameter int N = 8,
    parameter logic [7:0] RSVD2 = 8'h00
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic [2*N-1:0] sel,
    input wire logic [N-1:0] gpio_o,
    input wire gpm_pkg::gpm_drv_s fn1,
    input wire gpm_pkg::gpm_drv_s fn2,
    // Pins
    input wire logic [N-1:0] pin_i,
    output logic [N-1:0] pin_o_r,
    output logic [N-1:0] pin_oe_n_r,
    // Routed inputs
    output logic [N-1:0] pin_in_r,
    output logic [N-1:0] fn1_in_r,
    output logic [N-1:0] fn2_in_r
);
    // A port wider than the shared drive carrier cannot be served
    if (N < 1 || N > gpm_pkg::PIN_MAX)
    begin : g_bad_n
        $error("gpm_port_mux: N out of range");
    end

    logic [N-1:0] s1_r, s2_r, s3_r;
    logic [N-1:0] is_gpi, is_gpo, is_f1, is_f2, hiz;

    for (genvar i = 0; i < N; i++)
    begin : g_pin
        logic [1:0] s;
        assign s = sel[2*i+1:2*i];
        assign is_gpi[i] = (s == gpm_pkg::SEL_GPI);
        assign is_gpo[i] = (s == gpm_pkg::SEL_GPO);
        assign is_f1[i] = (s == gpm_pkg::SEL_FN1);
        assign is_f2[i] = (s == gpm_pkg::SEL_FN2) && !RSVD2[i];
        assign hiz[i] = is_gpi[i] || ((s == gpm_pkg::SEL_FN2) && RSVD2[i]);

        // Three-stage synchroniser; the level is taken only once stages two and three agree
        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                s1_r[i] <= 1'b0;
                s2_r[i] <= 1'b0;
                s3_r[i] <= 1'b0;
                pin_in_r[i] <= 1'b0;
            end
            else
            begin
                s1_r[i] <= pin_i[i];
                s2_r[i] <= s1_r[i];
                s3_r[i] <= s2_r[i];
                if (s2_r[i] == s3_r[i])
                begin
                    pin_in_r[i] <= s3_r[i];
                end
            end
        end

        // At most one source drives each pin; input and reserved codes drive none
        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                pin_o_r[i] <= 1'b0;
                pin_oe_n_r[i] <= 1'b1;
            end
            else
            begin
                pin_o_r[i] <= (is_gpo[i] && gpio_o[i]) || (is_f1[i] && fn1.o[i]) || (is_f2[i] && fn2.o[i]);
                pin_oe_n_r[i] <= !(is_gpo[i] || (is_f1[i] && !fn1.oe_n[i]) || (is_f2[i] && !fn2.oe_n[i]));
            end
        end
    end

    // Functions see zero unless their code is selected
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fn1_in_r <= '0;
            fn2_in_r <= '0;
        end
        else
        begin
            fn1_in_r <= pin_in_r & is_f1;
            fn2_in_r <= pin_in_r & is_f2;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_GPI_RELEASES: assert property (1'b1 |=> ((pin_oe_n_r & $past(hiz)) == $past(hiz)))
        else $error("input or reserved pin is driven");
    AST_GPO_DRIVES: assert property (1'b1 |=> (((pin_oe_n_r & $past(is_gpo)) == '0)
        && ((pin_o_r & $past(is_gpo)) == ($past(gpio_o) & $past(is_gpo)))))
        else $error("output pin does not follow its data bit");
    AST_RSVD_NOCONN: assert property (1'b1 |=> ((fn2_in_r & $past(hiz)) == '0))
        else $error("reserved code routed a pin to a function");
    AST_ONE_FN: assert property ((fn1_in_r & fn2_in_r) == '0)
        else $error("pin routed to two functions");
endmodule

// ===== gpm_pin_mux.sv
// Top of the GPIO pin function multiplexer: select registers on Avalon-MM and six port muxes.
// Assumes internal function blocks (PWM, keypad, two-wire, video out, cameras, panel) on clk.
// Notes on behaviour
// - Two-bit select per pin: 00 input, 10 output, 01 first, 11 second function.
// - Port A selects at 0C02h, two bits per pin; second function is camera two data.
// - Port B selects at 0C06h; second function on pin 7 drives camera strobe.
// - Port B pins 6 and 5 carry SDA and SCL; second code on pins 6-4 reserved.
// - Port B second function: pin 3 camera two vsync, pin 2 its hsync.
// - Port B second function: pin 1 outputs camera two master clock, pin 0 takes pixel clock.
// - Port C selects at 0C0Ah; first drives video data byte, second takes camera one data.
// - Port D selects at 0C0Eh; first function pins 2-0 drive video clock and syncs.
// - Port D second: pin 3 pixel clock in, 2 master clock out, 1 hsync, 0 vsync.
// - Video out path delivers 4:2:2 data through routed data, clock and sync pins.
// - Port G selects at 0C1Ah bits 9-0; panel control or serial panel, else GPIO.
// - Port H six pins share bits 11-10 at 0C1Eh; first routes upper panel data.
// - Sixteen-bit camera: camera two data low byte, camera one data high byte.
// - Each pin connects to at most one selected function; reserved codes connect none.
// - Keypad uses port A pins 4-0 as columns and port B pins 4-0 as rows.
// - Port B pin 7 first function drives PWM white; port D pin 3 takes audio.
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ps
module gpm_pin_mux (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [15:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Port pins
    input wire logic [7:0] port_a_pins_i,
    output logic [7:0] port_a_pins_o,
    output logic [7:0] port_a_pins_oe_n,
    input wire logic [7:0] port_b_pins_i,
    output logic [7:0] port_b_pins_o,
    output logic [7:0] port_b_pins_oe_n,
    input wire logic [7:0] port_c_pins_i,
    output logic [7:0] port_c_pins_o,
    output logic [7:0] port_c_pins_oe_n,
    input wire logic [3:0] port_d_pins_i,
    output logic [3:0] port_d_pins_o,
    output logic [3:0] port_d_pins_oe_n,
    input wire logic [4:0] port_g_pins_i,
    output logic [4:0] port_g_pins_o,
    output logic [4:0] port_g_pins_oe_n,
    input wire logic [5:0] port_h_pins_i,
    output logic [5:0] port_h_pins_o,
    output logic [5:0] port_h_pins_oe_n,
    // PWM and audio
    input wire logic pwm_red_out,
    input wire logic pwm_green_out,
    input wire logic pwm_blue_out,
    input wire logic pwm_white_out,
    output logic sound_input_for_pwm,
    // Keypad
    input wire logic [4:0] keypad_column_line,
    output logic [4:0] keypad_row_line,
    // Two-wire serial, open drain
    input wire logic sda_o,
    input wire logic sda_oe_n,
    input wire logic scl_o,
    input wire logic scl_oe_n,
    output logic sda_in,
    output logic scl_in,
    // Video out
    input wire logic [7:0] video_out_data,
    input wire logic video_out_clock,
    input wire logic video_out_hsync,
    input wire logic video_out_vsync,
    // Cameras
    input wire logic camera_strobe_out,
    input wire logic first_camera_master_clock,
    input wire logic second_camera_master_clock,
    output logic [7:0] first_camera_data,
    output logic first_camera_pixel_clock,
    output logic first_camera_hsync,
    output logic first_camera_vsync,
    output logic [7:0] second_camera_data,
    output logic second_camera_pixel_clock,
    output logic second_camera_hsync,
    output logic second_camera_vsync,
    output logic [15:0] camera_wide_data,
    // Panel
    input wire logic [4:0] panel_ext_ctrl,
    input wire logic [4:0] panel_serial_ctrl,
    input wire logic [5:0] panel_data_lines
);
    logic [15:0] sel_r [gpm_pkg::NPORT];
    logic [7:0] gpo_r [gpm_pkg::NPORT];
    logic [7:0] gpi [gpm_pkg::NPORT];
    logic mode_r;
    logic wait_r;
    logic [31:0] rd_nxt;
    logic acc, word_ok;
    logic [13:0] idx;
    logic [15:0] lane_m;
    gpm_pkg::gpm_drv_s fa1, fa2, fb1, fb2, fc1, fc2, fd1, fd2, fg1, fg2, fh1, fh2;
    logic [7:0] a_in2, b_in1, b_in2, c_in2;
    logic [3:0] d_in1, d_in2;

    assign idx = avs_address[15:2];
    assign word_ok = (avs_address[1:0] == 2'h0);
    assign lane_m = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    // A request is answered one cycle after it is seen and takes effect at that edge
    assign acc = !wait_r && (avs_read || avs_write);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wait_r <= 1'b1;
        end
        else
        begin
            wait_r <= !(wait_r && (avs_read || avs_write));
        end
    end

    always_comb
    begin
        rd_nxt = 32'h0000_0000;
        for (int p = 0; p < gpm_pkg::NPORT; p++)
        begin
            if (word_ok && idx == gpm_pkg::SEL_IDX[p])
            begin
                rd_nxt[15:0] = sel_r[p];
            end
            if (word_ok && idx == gpm_pkg::IDX_OUT_BASE + 14'(p))
            begin
                rd_nxt[7:0] = gpo_r[p];
            end
            if (word_ok && idx == gpm_pkg::IDX_IN_BASE + 14'(p))
            begin
                rd_nxt[7:0] = gpi[p];
            end
        end
        if (word_ok && idx == gpm_pkg::IDX_MODE)
        begin
            rd_nxt[gpm_pkg::MODE_CAM16_BIT] = mode_r;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            avs_readdata <= 32'h0000_0000;
        end
        else if (wait_r && avs_read)
        begin
            avs_readdata <= rd_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int p = 0; p < gpm_pkg::NPORT; p++)
            begin
                sel_r[p] <= gpm_pkg::SEL_RST;
                gpo_r[p] <= gpm_pkg::GPO_RST;
            end
            mode_r <= 1'b0;
        end
        else if (acc && avs_write && word_ok)
        begin
            for (int p = 0; p < gpm_pkg::NPORT; p++)
            begin
                // Unimplemented select bits stay zero
                if (idx == gpm_pkg::SEL_IDX[p])
                begin
                    sel_r[p] <= (sel_r[p] & ~(lane_m & gpm_pkg::SEL_WMASK[p]))
                        | (avs_writedata[15:0] & lane_m & gpm_pkg::SEL_WMASK[p]);
                end
                if (idx == gpm_pkg::IDX_OUT_BASE + 14'(p) && avs_byteenable[0])
                begin
                    gpo_r[p] <= avs_writedata[7:0];
                end
            end
            if (idx == gpm_pkg::IDX_MODE && avs_byteenable[0])
            begin
                mode_r <= avs_writedata[gpm_pkg::MODE_CAM16_BIT];
            end
        end
    end

    assign avs_waitrequest = wait_r;

    // Port A: PWM colour and keypad columns, or camera two data
    assign fa1.o = {pwm_red_out, pwm_green_out, pwm_blue_out, keypad_column_line};
    assign fa1.oe_n = 8'h00;
    assign fa2.o = 8'h00;
    assign fa2.oe_n = 8'hFF;
    // Port B: white PWM, two-wire, keypad rows; or strobe and camera two control
    assign fb1.o = {pwm_white_out, sda_o, scl_o, 5'h00};
    assign fb1.oe_n = {1'b0, sda_oe_n, scl_oe_n, 5'h1F};
    assign fb2.o = {camera_strobe_out, 5'h00, second_camera_master_clock, 1'b0};
    assign fb2.oe_n = 8'h7D;
    // Port C: video data byte or camera one data
    assign fc1.o = video_out_data;
    assign fc1.oe_n = 8'h00;
    assign fc2.o = 8'h00;
    assign fc2.oe_n = 8'hFF;
    // Port D: audio in and video timing, or camera one timing
    assign fd1.o = {4'h0, 1'b0, video_out_clock, video_out_hsync, video_out_vsync};
    assign fd1.oe_n = 8'hF8;
    assign fd2.o = {4'h0, 1'b0, first_camera_master_clock, 2'h0};
    assign fd2.oe_n = 8'hFB;
    // Port G: extended panel control or serial panel
    assign fg1.o = {3'h0, panel_ext_ctrl};
    assign fg1.oe_n = 8'hE0;
    assign fg2.o = {3'h0, panel_serial_ctrl};
    assign fg2.oe_n = 8'hE0;
    // Port H: upper panel data lines
    assign fh1.o = {2'h0, panel_data_lines};
    assign fh1.oe_n = 8'hC0;
    assign fh2.o = 8'h00;
    assign fh2.oe_n = 8'hFF;

    gpm_port_mux #(.N(8), .RSVD2(gpm_pkg::RSVD2_NONE)) u_port_a (
        .clk(clk), .rst_n(rst_n), .sel(sel_r[0]), .gpio_o(gpo_r[0]), .fn1(fa1), .fn2(fa2),
        .pin_i(port_a_pins_i), .pin_o_r(port_a_pins_o), .pin_oe_n_r(port_a_pins_oe_n),
        .pin_in_r(gpi[0]), .fn1_in_r(), .fn2_in_r(a_in2));
    gpm_port_mux #(.N(8), .RSVD2(gpm_pkg::RSVD2_B)) u_port_b (
        .clk(clk), .rst_n(rst_n), .sel(sel_r[1]), .gpio_o(gpo_r[1]), .fn1(fb1), .fn2(fb2),
        .pin_i(port_b_pins_i), .pin_o_r(port_b_pins_o), .pin_oe_n_r(port_b_pins_oe_n),
        .pin_in_r(gpi[1]), .fn1_in_r(b_in1), .fn2_in_r(b_in2));
    gpm_port_mux #(.N(8), .RSVD2(gpm_pkg::RSVD2_NONE)) u_port_c (
        .clk(clk), .rst_n(rst_n), .sel(sel_r[2]), .gpio_o(gpo_r[2]), .fn1(fc1), .fn2(fc2),
        .pin_i(port_c_pins_i), .pin_o_r(port_c_pins_o), .pin_oe_n_r(port_c_pins_oe_n),
        .pin_in_r(gpi[2]), .fn1_in_r(), .fn2_in_r(c_in2));
    gpm_port_mux #(.N(4), .RSVD2(gpm_pkg::RSVD2_NONE)) u_port_d (
        .clk(clk), .rst_n(rst_n), .sel(sel_r[3][7:0]), .gpio_o(gpo_r[3][3:0]), .fn1(fd1), .fn2(fd2),
        .pin_i(port_d_pins_i), .pin_o_r(port_d_pins_o), .pin_oe_n_r(port_d_pins_oe_n),
        .pin_in_r(gpi[3][3:0]), .fn1_in_r(d_in1), .fn2_in_r(d_in2));
    gpm_port_mux #(.N(5), .RSVD2(gpm_pkg::RSVD2_NONE)) u_port_g (
        .clk(clk), .rst_n(rst_n), .sel(sel_r[4][9:0]), .gpio_o(gpo_r[4][4:0]), .fn1(fg1), .fn2(fg2),
        .pin_i(port_g_pins_i), .pin_o_r(port_g_pins_o), .pin_oe_n_r(port_g_pins_oe_n),
        .pin_in_r(gpi[4][4:0]), .fn1_in_r(), .fn2_in_r());
    // One shared field steers all six pins of port H
    gpm_port_mux #(.N(6), .RSVD2(gpm_pkg::RSVD2_H)) u_port_h (
        .clk(clk), .rst_n(rst_n), .sel({6{sel_r[5][gpm_pkg::H_SEL_LSB+1:gpm_pkg::H_SEL_LSB]}}),
        .gpio_o(gpo_r[5][5:0]), .fn1(fh1), .fn2(fh2),
        .pin_i(port_h_pins_i), .pin_o_r(port_h_pins_o), .pin_oe_n_r(port_h_pins_oe_n),
        .pin_in_r(gpi[5][5:0]), .fn1_in_r(), .fn2_in_r());
    assign gpi[3][7:4] = 4'h0;
    assign gpi[4][7:5] = 3'h0;
    assign gpi[5][7:6] = 2'h0;

    // Routed inputs toward the internal functions
    assign keypad_row_line = b_in1[4:0];
    assign sda_in = b_in1[6];
    assign scl_in = b_in1[5];
    assign sound_input_for_pwm = d_in1[3];
    assign second_camera_data = a_in2;
    assign second_camera_vsync = b_in2[3];
    assign second_camera_hsync = b_in2[2];
    assign second_camera_pixel_clock = b_in2[0];
    assign first_camera_data = c_in2;
    assign first_camera_pixel_clock = d_in2[3];
    assign first_camera_hsync = d_in2[1];
    assign first_camera_vsync = d_in2[0];

    // Wide camera word is held at zero unless both data ports carry camera data,
    // so a half-programmed mux never hands the camera block a mixed word
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            camera_wide_data <= 16'h0000;
        end
        else
        begin
            camera_wide_data <= (mode_r && (&sel_r[0]) && (&sel_r[2])) ? {c_in2, a_in2} : 16'h0000;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    AST_PORTA_WRITE: assert property (acc && avs_write && avs_address == {gpm_pkg::IDX_SEL_A, 2'h0}
        && avs_byteenable[1] |=> sel_r[0][15:14] == $past(avs_writedata[15:14]))
        else $error("port A select write lost");
    AST_STROBE: assert property (sel_r[1][15:14] == gpm_pkg::SEL_FN2 |=> port_b_pins_o[7]
        == $past(camera_strobe_out) && !port_b_pins_oe_n[7])
        else $error("strobe not on port B pin 7");
    AST_I2C_OD: assert property (sel_r[1][13:12] == gpm_pkg::SEL_FN1 |=> port_b_pins_oe_n[6]
        == $past(sda_oe_n) && port_b_pins_o[6] == $past(sda_o))
        else $error("SDA not routed to port B pin 6");
    AST_VIDEO_CLK: assert property (sel_r[3][5:4] == gpm_pkg::SEL_FN1 |=> port_d_pins_o[2]
        == $past(video_out_clock) && !port_d_pins_oe_n[2])
        else $error("video clock not on port D pin 2");
    AST_H_SHARED: assert property ((&port_h_pins_oe_n) || !(|port_h_pins_oe_n))
        else $error("port H pins disagree on direction");
    AST_CAM16: assert property (!mode_r |=> camera_wide_data == 16'h0000)
        else $error("wide camera word outside wide mode");

    COV_WRITE: cover property (acc && avs_write);
    COV_READ: cover property (acc && avs_read && avs_readdata != 32'h0000_0000);
    COV_CAM16: cover property (camera_wide_data != 16'h0000);
endmodule

// ===== gpm_periph_model.sv
// External peripherals on the multiplexed pins: cameras, keypad, two-wire, panel.
// Assumes pins packed as {A,B,C,D,G,H}, 39 bits, with active-low device enables.
`timescale 1ns/1ps
module gpm_periph_model (
    // Device drive
    input wire logic [38:0] dev_o,
    input wire logic [38:0] dev_oe_n,
    // Levels the peripherals put on released pins
    input wire logic [38:0] ext,
    // Levels seen by the device
    output logic [38:0] pin_i
);
    // A driven pin shows the device level; a released pin, such as a camera pixel clock or sync, shows ext
    always_comb
    begin
        for (int k = 0; k < 39; k++)
        begin
            pin_i[k] = dev_oe_n[k] ? ext[k] : dev_o[k];
        end
    end
endmodule

// ===== gpio_function_pin_mux_test.sv
// Self-checking bench of the pin multiplexer: select table, routing, readback.
// Assumes gpm_pin_mux with one 100 MHz clock and the peripheral model beside it.
`timescale 1ns/1ps
module gpio_function_pin_mux_test;
    typedef struct packed {logic [2:0] p; logic [15:0] sel; logic [7:0] o; logic [7:0] oe;} gpm_row_s;
    logic clk, rst_n, avs_read, avs_write, sda_o, sda_oe_n, scl_o, scl_oe_n, sound_input_for_pwm;
    logic pwm_red_out, pwm_green_out, pwm_blue_out, pwm_white_out, sda_in, scl_in, avs_waitrequest;
    logic video_out_clock, video_out_hsync, video_out_vsync, camera_strobe_out;
    logic first_camera_master_clock, second_camera_master_clock, first_camera_pixel_clock;
    logic first_camera_hsync, first_camera_vsync, second_camera_pixel_clock;
    logic second_camera_hsync, second_camera_vsync;
    logic [15:0] avs_address, camera_wide_data;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic [7:0] port_a_pins_o, port_a_pins_oe_n, port_b_pins_o, port_b_pins_oe_n, port_c_pins_o, port_c_pins_oe_n;
    logic [3:0] port_d_pins_o, port_d_pins_oe_n;
    logic [4:0] port_g_pins_o, port_g_pins_oe_n, keypad_column_line, keypad_row_line, panel_ext_ctrl;
    logic [4:0] panel_serial_ctrl;
    logic [5:0] port_h_pins_o, port_h_pins_oe_n, panel_data_lines;
    logic [7:0] video_out_data, first_camera_data, second_camera_data;
    logic [38:0] ext;
    wire [7:0] port_a_pins_i, port_b_pins_i, port_c_pins_i;
    wire [3:0] port_d_pins_i;
    wire [4:0] port_g_pins_i;
    wire [5:0] port_h_pins_i;
    wire [38:0] dev_o = {port_a_pins_o, port_b_pins_o, port_c_pins_o, port_d_pins_o, port_g_pins_o, port_h_pins_o};
    wire [38:0] dev_oe = {port_a_pins_oe_n, port_b_pins_oe_n, port_c_pins_oe_n, port_d_pins_oe_n, port_g_pins_oe_n,
        port_h_pins_oe_n};
    int miscompares = 0;
    int check_count = 0;
    int cyc = 0;
    int off [6] = '{31, 23, 15, 11, 6, 0};
    int wid [6] = '{8, 8, 8, 4, 5, 6};
    // Every field of a port set to one code; o holds the driven bits only
    gpm_row_s rows [19] = '{'{3'h0, 16'h0000, 8'h00, 8'hFF}, '{3'h0, 16'hAAAA, 8'h3C, 8'h00},
        '{3'h0, 16'h5555, 8'hB5, 8'h00}, '{3'h0, 16'hFFFF, 8'h00, 8'hFF}, '{3'h1, 16'h5555, 8'h80, 8'h3F},
        '{3'h1, 16'hAAAA, 8'h3C, 8'h00}, '{3'h1, 16'hFFFF, 8'h82, 8'h7D}, '{3'h2, 16'h5555, 8'hA5, 8'h00},
        '{3'h2, 16'hAAAA, 8'h3C, 8'h00}, '{3'h2, 16'hFFFF, 8'h00, 8'hFF}, '{3'h3, 16'h0055, 8'h05, 8'h08},
        '{3'h3, 16'h00AA, 8'h0C, 8'h00}, '{3'h3, 16'h00FF, 8'h04, 8'h0B}, '{3'h4, 16'h0155, 8'h0B, 8'h00},
        '{3'h4, 16'h03FF, 8'h14, 8'h00}, '{3'h4, 16'h02AA, 8'h1C, 8'h00}, '{3'h5, 16'h0400, 8'h2D, 8'h00},
        '{3'h5, 16'h0800, 8'h3C, 8'h00}, '{3'h5, 16'h0C00, 8'h00, 8'h3F}};

    gpm_pin_mux uut (.*);
    gpm_periph_model peri (.dev_o(dev_o), .dev_oe_n(dev_oe), .ext(ext), .pin_i({port_a_pins_i, port_b_pins_i,
        port_c_pins_i, port_d_pins_i, port_g_pins_i, port_h_pins_i}));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task end_of_test;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
        begin
            $display("Result: passed");
        end
        else
        begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Hangs are cut off well beyond the few hundred cycles the tests need
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            miscompares++;
            end_of_test();
        end
    end

    task chk(input logic [39:0] got, input logic [39:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Request is held until waitrequest is sampled low at a rising edge; read data is taken at that edge
    task bus(input logic wr, input logic [13:0] idx, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        avs_address <= {idx, 2'h0};
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do
        begin
            @(posedge clk);
        end
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task wr(input logic [13:0] idx, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, q);
        repeat (3) @(negedge clk);
    endtask

    task rd(input logic [13:0] idx, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, idx, 32'h0, q);
        chk(q, exp);
    endtask

    initial
    begin
        {rst_n, avs_read, avs_write, sda_o, sda_oe_n, scl_o} = 6'h00;
        {scl_oe_n, pwm_red_out, pwm_green_out, pwm_blue_out, pwm_white_out} = 5'h1B;
        {video_out_clock, video_out_hsync, video_out_vsync, camera_strobe_out} = 4'hB;
        {first_camera_master_clock, second_camera_master_clock} = 2'h3;
        avs_address = 16'h0000;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        keypad_column_line = 5'h15;
        video_out_data = 8'hA5;
        panel_ext_ctrl = 5'h0B;
        panel_serial_ctrl = 5'h14;
        panel_data_lines = 6'h2D;
        ext = 39'h0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            rd(gpm_pkg::SEL_IDX[i], 32'h0);
        end
        chk(dev_oe, 39'h7FFFFFFFFF);
        $display("test reset done");
        for (int i = 0; i < 6; i++)
        begin
            wr(gpm_pkg::IDX_OUT_BASE + 14'(i), 32'h3C);
        end
        foreach (rows[i])
        begin
            wr(gpm_pkg::SEL_IDX[rows[i].p], {16'h0, rows[i].sel});
            chk((dev_oe >> off[rows[i].p]) & ((40'h1 << wid[rows[i].p]) - 40'h1), rows[i].oe);
            chk((dev_o >> off[rows[i].p]) & ~rows[i].oe & ((40'h1 << wid[rows[i].p]) - 40'h1), rows[i].o);
        end
        $display("test select table done");
        wr(gpm_pkg::IDX_SEL_D, 32'hFFFF);
        rd(gpm_pkg::IDX_SEL_D, 32'h00FF);
        rd(14'h0C03, 32'h0);
        $display("test readback done");
        // Ports A, B, C on the second function and D on camera one; PWM colour stays off port A
        @(posedge clk);
        ext <= {8'h69, 8'h6D, 8'h96, 4'hA, 11'h0};
        wr(gpm_pkg::IDX_MODE, 32'h1);
        repeat (6) @(negedge clk);
        chk(second_camera_data, 8'h69);
        chk({second_camera_vsync, second_camera_hsync, second_camera_pixel_clock}, 3'h7);
        chk(first_camera_data, 8'h96);
        chk({first_camera_pixel_clock, first_camera_hsync, first_camera_vsync}, 3'h6);
        chk(camera_wide_data, 16'h9669);
        chk({sda_in, scl_in, keypad_row_line}, 7'h0);
        $display("test camera routing done");
        wr(gpm_pkg::IDX_SEL_C, 32'h0);
        repeat (6) @(negedge clk);
        rd(gpm_pkg::IDX_IN_BASE + 14'h2, 32'h96);
        chk({first_camera_data, camera_wide_data}, 24'h0);
        $display("test input status done");
        // SDA driven low by the device, SCL and keypad rows from the far side, audio on port D pin 3
        wr(gpm_pkg::IDX_SEL_B, 32'h5555);
        wr(gpm_pkg::IDX_SEL_D, 32'h0055);
        repeat (6) @(negedge clk);
        chk({sda_in, scl_in, keypad_row_line, sound_input_for_pwm}, 8'h5B);
        $display("test first function inputs done");
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd(gpm_pkg::IDX_SEL_A, 32'h0);
        chk(dev_oe, 39'h7FFFFFFFFF);
        $display("test second reset done");
        end_of_test();
    end
endmodule
